/* File: hdl/ebram_core.v */
`timescale 1ns/1ps
`default_nettype none
`include "ebram_defs.vh"
module ebram_core (
   input wire core_clk, // System clock, 100 MHz
   input wire srst, // Synchronous reset, active high
   input wire globalResetN, // Device-wide async reset, low active
   input wire [1:0] memMode, // SP, TDP, PDP or FIFO
   input wire [2:0] widthSelA, // Port A width code
   input wire [2:0] widthSelB, // Port B width code
   input wire outRegA, // Port A output register on
   input wire outRegB, // Port B output register on
   input wire asyncOutReset, // Port resets act asynchronously
   input wire portAOutputReset, // Clears port A output only
   input wire portBOutputReset, // Clears port B output only
   input wire clkEnA, // Port A clock enable
   input wire clkEnB, // Port B clock enable / FIFO pop
   input wire writeEnA, // Port A write / FIFO push
   input wire writeEnB, // Port B write
   input wire [12:0] addrA, // Port A word address
   input wire [12:0] addrB, // Port B word address
   input wire [17:0] dataInA, // Port A write data
   input wire [17:0] dataInB, // Port B write data
   output wire [17:0] dataOutA, // Port A read data
   output wire [17:0] dataOutB, // Port B read data
   input wire readPointerReset, // FIFO read pointer rewind
   output wire fifoEmpty, // FIFO has no full read word
   output wire fifoFull, // FIFO has no room for a write word
   input wire initStart, // Begin preload
   input wire initZero, // Preload pattern is all zero
   input wire [15:0] initBase, // Pattern base in flash space
   output wire flashReqValid, // Fetch request to flash
   output wire [15:0] flashReqAddr, // Fetch word address
   input wire flashReqReady, // Flash takes request
   input wire flashDataValid, // Flash returns a word
   input wire [8:0] flashData, // Returned preload word
   output wire flashDataReady, // Room in the preload buffer
   output wire initBusy // Preload in progress, ports blocked
);
   reg mem [0:9215];
   reg [2:0] state;
   reg [10:0] reqCount;
   reg [10:0] wordCount;
   reg [13:0] baseRegA;
   reg [13:0] baseRegB;
   reg [17:0] dataRegA;
   reg [17:0] dataRegB;
   reg weRegA;
   reg weRegB;
   reg [14:0] wrPtr;
   reg [14:0] rdPtr;
   reg [14:0] fillBits;
   reg [17:0] rawA;
   reg [17:0] rawB;
   wire [2:0] codeA;
   wire [2:0] codeB;
   wire [4:0] wA;
   wire [4:0] wB;
   wire wide;
   wire fifoMode;
   wire pushA;
   wire popB;
   wire wrOkA;
   wire wrOkB;
   wire rdA;
   wire rdB;
   wire bufValid;
   wire [8:0] bufData;
   wire [13:0] initBase9;
   integer i;

   // ----------------------------------------
   // Width and address mapping
   // ----------------------------------------
   // Bits per word for a width code
   function [4:0] widthOf;
      input [2:0] code;
      begin
         case (code)
            `EBRAM_W1: widthOf = 5'h01; // RULE1
            `EBRAM_W2: widthOf = 5'h02;
            `EBRAM_W4: widthOf = 5'h04;
            `EBRAM_W18: widthOf = 5'h12; // RULE2
            default: widthOf = 5'h09;
         endcase
      end
   endfunction

   // First array bit of a word: word n occupies n*w .. n*w+w-1
   function [13:0] bitBase;
      input [12:0] addr;
      input [2:0] code;
      begin
         case (code)
            `EBRAM_W1: bitBase = {1'b0, addr}; // RULE4
            `EBRAM_W2: bitBase = {1'b0, addr[11:0], 1'b0};
            `EBRAM_W4: bitBase = {1'b0, addr[10:0], 2'b00};
            `EBRAM_W18: bitBase = {5'h00, addr[8:0]} * 14'h0012;
            default: bitBase = {4'h0, addr[9:0]} * 14'h0009;
         endcase
      end
   endfunction

   // 512x18 only where one port reads and the other writes
   assign wide = (memMode == `EBRAM_MODE_PDP) || (memMode == `EBRAM_MODE_FIFO); // RULE2
   // Each port keeps its own width code
   assign codeA = (widthSelA == `EBRAM_W18 && !wide) ? `EBRAM_W9 : widthSelA; // RULE3
   assign codeB = (widthSelB == `EBRAM_W18 && !wide) ? `EBRAM_W9 : widthSelB; // RULE3
   assign wA = widthOf(codeA);
   assign wB = widthOf(codeB);

   // ----------------------------------------
   // Port permissions per mode
   // ----------------------------------------
   assign fifoMode = (memMode == `EBRAM_MODE_FIFO);
   assign initBusy = ~state[0];
   assign fifoEmpty = (fillBits < {10'h000, wB});
   assign fifoFull = ((`EBRAM_BITS - fillBits) < {10'h000, wA});
   assign pushA = fifoMode & clkEnA & writeEnA & ~fifoFull & ~initBusy;
   assign popB = fifoMode & clkEnB & ~fifoEmpty & ~initBusy;
   // Port A writes in every RAM mode; B only in true dual
   assign wrOkA = ~initBusy & ~fifoMode & clkEnA & writeEnA;
   assign wrOkB = ~initBusy & (memMode == `EBRAM_MODE_TDP) & clkEnB & writeEnB;
   assign rdA = ~initBusy & clkEnA &
      ((memMode == `EBRAM_MODE_SP) || (memMode == `EBRAM_MODE_TDP));
   assign rdB = ~initBusy & ((memMode == `EBRAM_MODE_TDP) ||
      (memMode == `EBRAM_MODE_PDP)) & clkEnB;

   // ----------------------------------------
   // Input registers at the array
   // ----------------------------------------
   // Writes land one edge after capture, from these registers only
   always @(posedge core_clk) begin
      if (srst) begin
         baseRegA <= 14'h0000;
         baseRegB <= 14'h0000;
         dataRegA <= 18'h00000;
         dataRegB <= 18'h00000;
         weRegA <= 1'b0;
         weRegB <= 1'b0;
      end else begin
         weRegA <= wrOkA | pushA; // RULE8
         weRegB <= wrOkB; // RULE8
         if (pushA) begin
            baseRegA <= wrPtr[13:0];
            dataRegA <= dataInA;
         end else if (clkEnA) begin
            baseRegA <= bitBase(addrA, codeA); // RULE8
            dataRegA <= dataInA;
         end
         if (popB) begin
            baseRegB <= rdPtr[13:0];
         end else if (clkEnB && !fifoMode) begin
            baseRegB <= bitBase(addrB, codeB); // RULE8
            dataRegB <= dataInB;
         end
      end
   end

   // ----------------------------------------
   // FIFO pointers and fill level
   // ----------------------------------------
   // Rewind assumes the write pointer has not wrapped since the start
   always @(posedge core_clk) begin
      if (srst || !fifoMode) begin
         wrPtr <= 15'h0000;
         rdPtr <= 15'h0000;
         fillBits <= 15'h0000;
      end else begin
         if (pushA)
            wrPtr <= (wrPtr + {10'h000, wA} >= `EBRAM_BITS) ?
               wrPtr + {10'h000, wA} - `EBRAM_BITS : wrPtr + {10'h000, wA};
         if (readPointerReset) begin
            rdPtr <= 15'h0000; // RULE10
            fillBits <= wrPtr + (pushA ? {10'h000, wA} : 15'h0000); // RULE10
         end else begin
            if (popB)
               rdPtr <= (rdPtr + {10'h000, wB} >= `EBRAM_BITS) ?
                  rdPtr + {10'h000, wB} - `EBRAM_BITS : rdPtr + {10'h000, wB};
            fillBits <= fillBits + (pushA ? {10'h000, wA} : 15'h0000)
               - (popB ? {10'h000, wB} : 15'h0000);
         end
      end
   end

   // ----------------------------------------
   // Preload sequencer
   // ----------------------------------------
   // A zero pattern clears in one cycle and fetches nothing from flash
   always @(posedge core_clk) begin
      if (srst) begin
         state <= `EBRAM_ST_IDLE;
         reqCount <= 11'h000;
         wordCount <= 11'h000;
      end else begin
         case (state)
            `EBRAM_ST_IDLE: begin
               reqCount <= 11'h000;
               wordCount <= 11'h000;
               if (initStart)
                  state <= initZero ? `EBRAM_ST_CLEAR : `EBRAM_ST_FETCH; // RULE5 RULE7
            end
            `EBRAM_ST_CLEAR: begin
               state <= `EBRAM_ST_IDLE;
            end
            `EBRAM_ST_FETCH: begin
               if (flashReqValid && flashReqReady)
                  reqCount <= reqCount + 11'h001;
               if (bufValid) begin
                  wordCount <= wordCount + 11'h001;
                  if (wordCount == `EBRAM_INIT_WORDS - 11'h001)
                     state <= `EBRAM_ST_IDLE;
               end
            end
            default: state <= `EBRAM_ST_IDLE;
         endcase
      end
   end

   // Blocks with one pattern point at one shared base
   assign flashReqValid = state[2] && (reqCount != `EBRAM_INIT_WORDS); // RULE5
   assign flashReqAddr = initBase + {5'h00, reqCount}; // RULE7
   assign initBase9 = {4'h0, wordCount[9:0]} * 14'h0009;

   // Flash words queue here; full buffer stalls the flash side
   ebram_fifo #(
      .W(`EBRAM_INIT_W),
      .DEPTH(`EBRAM_BUF_DEPTH),
      .AW(4)
   ) preloadBuf (
      .core_clk(core_clk),
      .srst(srst),
      .inValid(flashDataValid & state[2]),
      .inReady(flashDataReady),
      .inData(flashData),
      .outValid(bufValid),
      .outReady(state[2]),
      .outData(bufData)
   );

   // ----------------------------------------
   // Storage array
   // ----------------------------------------
   // Port B is applied last, so it wins a same-bit collision
   always @(posedge core_clk) begin
      if (state[1]) begin
         for (i = 0; i < 9216; i = i + 1)
            mem[i] <= 1'b0; // RULE7
      end else if (state[2] && bufValid) begin
         for (i = 0; i < 9; i = i + 1)
            mem[initBase9 + i] <= bufData[i]; // RULE5
      end else begin
         for (i = 0; i < 18; i = i + 1)
            if (weRegA && (i < wA))
               mem[baseRegA + i] <= dataRegA[i]; // RULE4
         for (i = 0; i < 18; i = i + 1)
            if (weRegB && (i < wB))
               mem[baseRegB + i] <= dataRegB[i];
      end
   end

   // Read words gathered from the registered bit base
   always @* begin
      rawA = 18'h00000;
      rawB = 18'h00000;
      for (i = 0; i < 18; i = i + 1) begin
         if (i < wA)
            rawA[i] = mem[baseRegA + i]; // RULE4
         if (i < wB)
            rawB[i] = mem[baseRegB + i];
      end
   end

   // ----------------------------------------
   // Output latches, one per port
   // ----------------------------------------
   ebram_out_stage #(.W(`EBRAM_DATA_W)) outStageA (
      .core_clk(core_clk),
      .srst(srst),
      .globalResetN(globalResetN), // RULE13
      .asyncStyle(asyncOutReset),
      .portReset(portAOutputReset), // RULE12
      .clkEn(clkEnA),
      .readTaken(rdA),
      .outRegEn(outRegA),
      .rawData(rawA),
      .dataOut(dataOutA)
   );

   ebram_out_stage #(.W(`EBRAM_DATA_W)) outStageB (
      .core_clk(core_clk),
      .srst(srst),
      .globalResetN(globalResetN), // RULE13
      .asyncStyle(asyncOutReset),
      .portReset(portBOutputReset), // RULE12
      .clkEn(clkEnB),
      .readTaken(rdB | popB),
      .outRegEn(outRegB),
      .rawData(rawB),
      .dataOut(dataOutB)
   );
endmodule // ebram_core
`default_nettype wire

/* File: hdl/ebram_defs.vh */
// Contract
// RULE1 - 8Kx1, 4Kx2, 2Kx4, 1Kx9 in single/true dual
// RULE2 - Pseudo dual and FIFO also offer 512x18
// RULE3 - Each port picks its own width
// RULE4 - Bits ordered LSB..MSB word 0, word 1...
// RULE5 - Optional preload at configuration from storage
// RULE6 - ROM use: preload, writes held disabled forever
// RULE7 - Zero pattern uses no flash; shared patterns
// RULE8 - Address and write data registered at array
// RULE9 - Optional output register, else unregistered read
// RULE10 - Read pointer reset rewinds FIFO for retransmit
// RULE11 - Output latches clear sync or async
// RULE12 - Per-port reset clears only its own latch
// RULE13 - Global reset clears both output latches
// RULE14 - Global reset always acts asynchronously
// RULE15 - Enables low one cycle around async reset
// RULE16 - Else clocks steady one period around reset
`ifndef EBRAM_DEFS_VH
`define EBRAM_DEFS_VH
// ----------------------------------------
// Array geometry
// ----------------------------------------
`define EBRAM_BITS 15'd9216
`define EBRAM_BIDX_W 14
`define EBRAM_ADDR_W 13
`define EBRAM_DATA_W 18
`define EBRAM_INIT_WORDS 11'd1024
`define EBRAM_INIT_W 9
`define EBRAM_FLASH_AW 16
// ----------------------------------------
// Memory modes
// ----------------------------------------
`define EBRAM_MODE_SP 2'h0
`define EBRAM_MODE_TDP 2'h1
`define EBRAM_MODE_PDP 2'h2
`define EBRAM_MODE_FIFO 2'h3
// ----------------------------------------
// Port width codes
// ----------------------------------------
`define EBRAM_W1 3'h0
`define EBRAM_W2 3'h1
`define EBRAM_W4 3'h2
`define EBRAM_W9 3'h3
`define EBRAM_W18 3'h4
// ----------------------------------------
// Preload buffer and loader states
// ----------------------------------------
`define EBRAM_BUF_DEPTH 16
`define EBRAM_ST_IDLE 3'h1
`define EBRAM_ST_CLEAR 3'h2
`define EBRAM_ST_FETCH 3'h4
`endif

/* File: hdl/ebram_fifo.v */
`timescale 1ns/1ps
`default_nettype none
module ebram_fifo #(
   parameter W = 9,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire core_clk, // System clock
   input wire srst, // Synchronous reset
   input wire inValid, // Fill side has a word
   output wire inReady, // Room for a word
   input wire [W-1:0] inData, // Fill side word
   output wire outValid, // A word is waiting
   input wire outReady, // Drain side takes it
   output wire [W-1:0] outData // Oldest word
);
   reg [W-1:0] store [0:DEPTH-1];
   reg [AW-1:0] wrIdx;
   reg [AW-1:0] rdIdx;
   reg [AW:0] count;
   wire push;
   wire pop;

   // ----------------------------------------
   // Flags straight from the occupancy count
   // ----------------------------------------
   assign inReady = (count != DEPTH[AW:0]);
   assign outValid = (count != {(AW+1){1'b0}});
   assign push = inValid & inReady;
   assign pop = outValid & outReady;
   assign outData = store[rdIdx];

   // Pointers wrap by modulo; depth must be a power of two
   always @(posedge core_clk) begin
      if (srst) begin
         wrIdx <= {AW{1'b0}};
         rdIdx <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            store[wrIdx] <= inData;
            wrIdx <= wrIdx + 1'b1;
         end
         if (pop)
            rdIdx <= rdIdx + 1'b1;
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end
endmodule // ebram_fifo
`default_nettype wire

/* File: hdl/ebram_out_stage.v */
`timescale 1ns/1ps
`default_nettype none
module ebram_out_stage #(
   parameter W = 18
) (
   input wire core_clk, // System clock
   input wire srst, // Synchronous block reset
   input wire globalResetN, // Device-wide reset, low active
   input wire asyncStyle, // 1: port reset acts asynchronously
   input wire portReset, // This port's own output reset
   input wire clkEn, // Port clock enable
   input wire readTaken, // A read was captured this edge
   input wire outRegEn, // Use the output register
   input wire [W-1:0] rawData, // Array read data
   output wire [W-1:0] dataOut // Port read data
);
   reg [W-1:0] pipeQ;
   reg cleared;
   wire asyncClr;

   // ----------------------------------------
   // Reset sources for the output latch
   // ----------------------------------------
   // Gated async clear can glitch; user keeps enables quiet around it
   assign asyncClr = ~globalResetN | (asyncStyle & portReset); // RULE11 RULE13 RULE14 RULE15

   // Latch and optional register; a clear holds until the next read
   always @(posedge core_clk or posedge asyncClr) begin
      if (asyncClr) begin
         pipeQ <= {W{1'b0}};
         cleared <= 1'b1;
      end else if (srst || (!asyncStyle && portReset)) begin // RULE11 RULE12
         pipeQ <= {W{1'b0}};
         cleared <= 1'b1;
      end else begin
         if (readTaken)
            cleared <= 1'b0;
         if (clkEn)
            pipeQ <= cleared ? {W{1'b0}} : rawData;
      end
   end

   // Registered or flow-through read data
   assign dataOut = outRegEn ? pipeQ : (cleared ? {W{1'b0}} : rawData); // RULE9
endmodule // ebram_out_stage
`default_nettype wire

/* File: testbench/ebram_core_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port-level checks on the memory core
// ----------------------------------------
module ebram_core_monitor (
   input wire logic core_clk, // System clock
   input wire logic srst, // Sync reset
   input wire logic globalResetN, // Device reset, low active
   input wire logic [1:0] memMode, // Memory mode
   input wire logic outRegA, // Port A output register on
   input wire logic asyncOutReset, // Port resets async
   input wire logic portAOutputReset, // Port A output clear
   input wire logic portBOutputReset, // Port B output clear
   input wire logic clkEnA, // Port A enable
   input wire logic clkEnB, // Port B enable
   input wire logic [17:0] dataOutA, // Port A read data
   input wire logic [17:0] dataOutB, // Port B read data
   input wire logic initStart, // Preload start
   input wire logic initZero, // Zero pattern
   input wire logic [15:0] initBase, // Pattern base
   input wire logic flashReqValid, // Fetch request
   input wire logic [15:0] flashReqAddr, // Fetch address
   input wire logic flashReqReady, // Fetch taken
   input wire logic initBusy // Preload running
);
   default clocking mon_cb @(posedge core_clk); endclocking
   default disable iff (srst);
   // Resets must win over any capture; global and async clears are checked at every sampled edge, sync clear only with the port enable low
   glob_clear_a: assert property (!globalResetN |-> dataOutA == 18'h0 && dataOutB == 18'h0)
      else $error("global reset left a port output set");
   async_clear_a: assert property (asyncOutReset && portAOutputReset |-> dataOutA == 18'h0)
      else $error("async port A clear not seen");
   sync_clear_a: assert property (!asyncOutReset && portAOutputReset && !clkEnA
      |=> dataOutA == 18'h0) else $error("sync port A clear not seen");
   port_iso_a: assert property (portAOutputReset && !portBOutputReset && !clkEnA && !clkEnB
      && !initBusy && memMode != 2'h3
      |=> $stable(dataOutB) || !globalResetN || portBOutputReset)
      else $error("port A clear disturbed port B");
   outreg_hold_a: assert property (outRegA && !clkEnA && !portAOutputReset && globalResetN
      |=> $stable(dataOutA) || !globalResetN || portAOutputReset)
      else $error("registered output moved without enable");
   zero_init_a: assert property (initStart && initZero && !initBusy
      |=> (initBusy && !flashReqValid) ##1 (!initBusy && !flashReqValid))
      else $error("zero preload fetched or overran");
   req_start_a: assert property (initStart && !initZero && !initBusy
      |=> initBusy && flashReqValid && flashReqAddr == $past(initBase))
      else $error("preload did not fetch from base");
   req_hold_a: assert property (flashReqValid && !flashReqReady
      |=> flashReqValid && $stable(flashReqAddr))
      else $error("fetch request dropped before taken");
endmodule // ebram_core_monitor
bind ebram_core ebram_core_monitor i_mon (.core_clk, .srst, .globalResetN, .memMode, .outRegA,
   .asyncOutReset, .portAOutputReset, .portBOutputReset, .clkEnA, .clkEnB, .dataOutA,
   .dataOutB, .initStart, .initZero, .initBase, .flashReqValid, .flashReqAddr,
   .flashReqReady, .initBusy);
`default_nettype wire

/* File: testbench/ebram_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Preload storage answering fetches in order
// ----------------------------------------
module ebram_flash_model (
   input wire logic core_clk, // System clock
   input wire logic srst, // Sync reset
   input wire logic slow, // 1: answer every other cycle
   input wire logic reqValid, // Fetch request
   input wire logic [15:0] reqAddr, // Fetch address
   output logic reqReady, // Request taken
   output logic dataValid, // Word returned
   output logic [8:0] data, // Returned word
   input wire logic dataReady // Buffer has room
);
   logic tick = 1'b0;
   logic [8:0] pend[$];
   // Stored word is the address folded with a mask; idle data toggles so stale values show
   always @(posedge core_clk) begin
      tick <= ~tick;
      if (srst) begin
         pend.delete();
         reqReady <= 1'b0;
         dataValid <= 1'b0;
         data <= 9'h000;
      end else begin
         if (reqValid && reqReady) pend.push_back(reqAddr[8:0] ^ 9'h0A5);
         if (dataValid && dataReady) void'(pend.pop_front());
         reqReady <= !slow || tick;
         if (pend.size() > 0 && (!slow || !tick)) begin
            dataValid <= 1'b1;
            data <= pend[0];
         end else begin
            dataValid <= 1'b0;
            data <= ~data;
         end
      end
   end
endmodule // ebram_flash_model
`default_nettype wire

/* File: testbench/embedded_block_ram_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ebram_defs.vh"
module embedded_block_ram_tb;
   logic core_clk = 1'b0, srst = 1'b1, globalResetN = 1'b1, slow = 1'b1;
   logic [1:0] memMode = 2'h0;
   logic [2:0] widthSelA = 3'h3, widthSelB = 3'h3;
   logic outRegA = 1'b0, outRegB = 1'b0, asyncOutReset = 1'b0;
   logic portAOutputReset = 1'b0, portBOutputReset = 1'b0, readPointerReset = 1'b0;
   logic clkEnA = 1'b0, clkEnB = 1'b0, writeEnA = 1'b0, writeEnB = 1'b0;
   logic [12:0] addrA = 13'h0000, addrB = 13'h0000;
   logic [17:0] dataInA = 18'h00000, dataInB = 18'h00000;
   logic initStart = 1'b0, initZero = 1'b0;
   logic [15:0] initBase = 16'h0000;
   wire logic [17:0] dataOutA, dataOutB;
   wire logic fifoEmpty, fifoFull, flashReqValid, flashReqReady, flashDataValid;
   wire logic flashDataReady, initBusy;
   wire logic [15:0] flashReqAddr;
   wire logic [8:0] flashData;
   int err_total = 0;
   int checks_done = 0;
   // ----------------------------------------
   // Clock, design and flash partner
   // ----------------------------------------
   initial forever #5 core_clk = ~core_clk;
   ebram_core i_dut (.core_clk, .srst, .globalResetN, .memMode, .widthSelA, .widthSelB,
      .outRegA, .outRegB, .asyncOutReset, .portAOutputReset, .portBOutputReset, .clkEnA,
      .clkEnB, .writeEnA, .writeEnB, .addrA, .addrB, .dataInA, .dataInB, .dataOutA, .dataOutB,
      .readPointerReset, .fifoEmpty, .fifoFull, .initStart, .initZero, .initBase, .flashReqValid,
      .flashReqAddr, .flashReqReady, .flashDataValid, .flashData, .flashDataReady, .initBusy);
   ebram_flash_model i_flash (.core_clk, .srst, .slow, .reqValid(flashReqValid),
      .reqAddr(flashReqAddr), .reqReady(flashReqReady), .dataValid(flashDataValid),
      .data(flashData), .dataReady(flashDataReady));
   // ----------------------------------------
   // Shared drivers and compare
   // ----------------------------------------
   task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Both address ports follow one address; only port A writes
   task automatic drv(input logic ceA, ceB, we, input logic [12:0] a, input logic [17:0] d);
      @(posedge core_clk);
      clkEnA <= ceA;
      clkEnB <= ceB;
      writeEnA <= we;
      addrA <= a;
      addrB <= a;
      dataInA <= d;
   endtask
   // Two captures so the registered path has its extra enabled edge too
   task automatic rd2(input logic [12:0] a);
      drv(1, 1, 0, a, 18'h0);
      drv(1, 1, 0, a, 18'h0);
      drv(0, 0, 0, a, 18'h0);
      #1;
   endtask
   task automatic preload(input logic zero);
      int n;
      @(posedge core_clk);
      initZero <= zero;
      initStart <= 1'b1;
      @(posedge core_clk);
      initStart <= 1'b0;
      n = 0;
      do begin
         @(posedge core_clk);
         #1 n++;
      end while (initBusy === 1'b1 && n < 20000);
      chk("preload idle", 18'h0, {17'h0, initBusy});
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_init;
      @(posedge core_clk);
      memMode <= `EBRAM_MODE_SP;
      initBase <= 16'h0100;
      preload(1'b0);
      rd2(13'h0003);
      chk("preload word 3", {9'h0, 9'h103 ^ 9'h0A5}, dataOutA);
      rd2(13'h03FF);
      chk("preload word 1023", {9'h0, 9'h0FF ^ 9'h0A5}, dataOutA);
      preload(1'b1);
      rd2(13'h0003);
      chk("zero preload", 18'h0, dataOutA);
      $display("t_init done");
   endtask
   task automatic t_rw;
      for (int r = 0; r < 2; r++) begin
         @(posedge core_clk);
         memMode <= r[1:0];
         outRegA <= r[0];
         outRegB <= r[0];
         drv(1, 0, 1, 13'h0005, 18'h001A5 + r);
         rd2(13'h0005);
         chk("read A", 18'h001A5 + r, dataOutA);
         if (r == 1) chk("read B", 18'h001A6, dataOutB);
      end
      $display("t_rw done");
   endtask
   task automatic t_mix;
      @(posedge core_clk);
      memMode <= `EBRAM_MODE_PDP;
      widthSelA <= `EBRAM_W1;
      widthSelB <= `EBRAM_W18;
      for (int k = 0; k < 9; k++) drv(1, 0, 1, k[12:0], {17'h0, k[0] ^ k[2] ^ (k > 6)});
      // Last x1 write must commit before the width moves
      drv(0, 0, 0, 13'h0, 18'h0);
      drv(0, 0, 0, 13'h0, 18'h0);
      widthSelA <= `EBRAM_W2;
      drv(1, 0, 1, 13'h0005, 18'h00003);
      rd2(13'h0000);
      chk("mixed widths", 18'h00DDA, dataOutB);
      @(posedge core_clk);
      widthSelA <= `EBRAM_W9;
      widthSelB <= `EBRAM_W9;
      $display("t_mix done");
   endtask
   task automatic t_rst;
      // Output path changes under reset, so no held output jumps mid-run
      @(posedge core_clk);
      srst <= 1'b1;
      memMode <= `EBRAM_MODE_TDP;
      outRegA <= 1'b0;
      outRegB <= 1'b0;
      asyncOutReset <= 1'b1;
      @(posedge core_clk);
      srst <= 1'b0;
      rd2(13'h0005);
      @(posedge core_clk);
      portAOutputReset <= 1'b1;
      #1 chk("async clear A", 18'h0, dataOutA);
      chk("B untouched", 18'h001A6, dataOutB);
      @(posedge core_clk);
      portAOutputReset <= 1'b0;
      asyncOutReset <= 1'b0;
      rd2(13'h0005);
      @(posedge core_clk);
      portBOutputReset <= 1'b1;
      #1 chk("sync B waits", 18'h001A6, dataOutB);
      @(posedge core_clk);
      portBOutputReset <= 1'b0;
      #1 chk("sync clear B", 18'h0, dataOutB);
      chk("A untouched", 18'h001A6, dataOutA);
      @(posedge core_clk);
      portAOutputReset <= 1'b1;
      @(posedge core_clk);
      portAOutputReset <= 1'b0;
      #1 chk("sync clear A", 18'h0, dataOutA);
      rd2(13'h0005);
      // Enables already low a cycle around the global reset
      @(posedge core_clk);
      #3 globalResetN = 1'b0;
      #1 chk("global clear A", 18'h0, dataOutA);
      chk("global clear B", 18'h0, dataOutB);
      @(posedge core_clk);
      #3 globalResetN = 1'b1;
      repeat (2) @(posedge core_clk);
      $display("t_rst done");
   endtask
   task automatic pop(input logic [17:0] exp);
      drv(0, 1, 0, 13'h0, 18'h0);
      drv(0, 0, 0, 13'h0, 18'h0);
      #1 chk("pop", exp, dataOutB);
   endtask
   task automatic t_fifo;
      @(posedge core_clk);
      srst <= 1'b1;
      memMode <= `EBRAM_MODE_FIFO;
      @(posedge core_clk);
      srst <= 1'b0;
      #1 chk("empty after reset", 18'h1, {17'h0, fifoEmpty});
      for (int i = 0; i < 3; i++) drv(1, 0, 1, 13'h0, 18'h000A0 + i);
      drv(0, 0, 0, 13'h0, 18'h0);
      drv(0, 0, 0, 13'h0, 18'h0);
      #1 chk("not empty", 18'h0, {17'h0, fifoEmpty});
      chk("not full", 18'h0, {17'h0, fifoFull});
      pop(18'h000A0);
      pop(18'h000A1);
      @(posedge core_clk);
      readPointerReset <= 1'b1;
      @(posedge core_clk);
      readPointerReset <= 1'b0;
      for (int i = 0; i < 3; i++) pop(18'h000A0 + i);
      drv(0, 0, 0, 13'h0, 18'h0);
      #1 chk("empty after replay", 18'h1, {17'h0, fifoEmpty});
      $display("t_fifo done");
   endtask
   // ----------------------------------------
   // Sequence, watchdog and verdict
   // ----------------------------------------
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      srst <= 1'b0;
      t_init();
      t_rw();
      t_mix();
      t_rst();
      t_fifo();
      test_done();
   end
   // Preload with stalls takes a few thousand cycles; the rest is short
   initial begin
      repeat (60000) @(posedge core_clk);
      err_total++;
      test_done();
   end
endmodule // embedded_block_ram_tb
`default_nettype wire
